/* File: phyan_defs.svh */
`ifndef PHYAN_DEFS_SVH
`define PHYAN_DEFS_SVH

/*
  Register offsets, field positions and reset values of the negotiation, preamble,
  error counter and interrupt register slice.
  Assumes inclusion by bare name from every design file that needs these numbers.
*/

// ----------------------------------------------------------------------------
// Register offsets.
// ----------------------------------------------------------------------------
`define PHYAN_OFS_PARTNER_ABILITY  5'h05
`define PHYAN_OFS_EXPANSION        5'h06
`define PHYAN_OFS_LOCAL_NEXT_PAGE  5'h07
`define PHYAN_OFS_PARTNER_NEXT     5'h08
`define PHYAN_OFS_PREAMBLE_CTRL    5'h14
`define PHYAN_OFS_SYMBOL_ERRORS    5'h15
`define PHYAN_OFS_IRQ_CTRL_STATUS  5'h1b

// ----------------------------------------------------------------------------
// Field positions.
// ----------------------------------------------------------------------------
`define PHYAN_EXP_PD_FAULT         4
`define PHYAN_EXP_PARTNER_NP       3
`define PHYAN_EXP_LOCAL_NP         2
`define PHYAN_EXP_PAGE_RCVD        1
`define PHYAN_EXP_PARTNER_AN       0
`define PHYAN_NP_MORE              15
`define PHYAN_NP_ACK               14
`define PHYAN_NP_MSG               13
`define PHYAN_NP_ACK2              12
`define PHYAN_NP_TOGGLE            11
`define PHYAN_PRE_100              7
`define PHYAN_PRE_10               6
`define PHYAN_IRQ_EN_LSB           8
`define PHYAN_IRQ_EVENTS           8

// ----------------------------------------------------------------------------
// Reset values.
// ----------------------------------------------------------------------------
`define PHYAN_RST_SELECTOR         5'h01
`define PHYAN_RST_LOCAL_NEXT_PAGE  16'h2001
`define PHYAN_RST_PREAMBLE_LOW     6'h01
`define PHYAN_STRAP_PREAMBLE_100   3'h4
`define PHYAN_STRAP_SETTLE         3'h5

`endif

/* File: phyan_pkg.sv */
/*
  Types shared by the register slice.
  Assumes the constants header supplies every number.
*/
package phyan_pkg;

  // --------------------------------------------------------------------------
  // Management access state.
  // --------------------------------------------------------------------------
  typedef enum logic [1:0] {
    PHYAN_IDLE,
    PHYAN_READ,
    PHYAN_WRITE
  } phyan_access_type;

endpackage : phyan_pkg

/* File: phyan_sync3.sv */
/*
  Three-stage synchroniser for pin inputs; a change counts once stages two and three agree.
  Assumes a free-running core clock and synchronous active-low reset.
*/
`timescale 1ns/1ps
module phyan_sync3 #(
  parameter int WIDTH = 1
) (
  // Clock and reset.
  input  wire logic             sys_clk,
  input  wire logic             nrst,
  // Data.
  input  wire logic [WIDTH-1:0] asyncIn,
  output logic      [WIDTH-1:0] syncOut
);

  logic [WIDTH-1:0] s1_q;
  logic [WIDTH-1:0] s2_q;
  logic [WIDTH-1:0] s3_q;

  always_ff @(posedge sys_clk) begin
    if (!nrst) begin
      s1_q    <= '0;
      s2_q    <= '0;
      s3_q    <= '0;
      syncOut <= '0;
    end else begin
      s1_q <= asyncIn;
      s2_q <= s1_q;
      s3_q <= s2_q;
      // A glitch shorter than two cycles never reaches the output.
      for (int i = 0; i < WIDTH; i++) begin
        if (s2_q[i] == s3_q[i]) begin
          syncOut[i] <= s3_q[i];
        end
      end
    end
  end

endmodule : phyan_sync3

/* File: phyan_event_flags.sv */
/*
  Sticky event flags that clear on read; a new event in the read cycle survives.
  Assumes events and the read strobe are one-cycle pulses on the core clock.
*/
`timescale 1ns/1ps
module phyan_event_flags #(
  parameter int N = 8
) (
  // Clock and reset.
  input  wire logic         sys_clk,
  input  wire logic         nrst,
  // Events and clear.
  input  wire logic [N-1:0] eventIn,
  input  wire logic         readClear,
  // Flags.
  output logic      [N-1:0] flags_q
);

  genvar g;
  generate
    for (g = 0; g < N; g++) begin : gFlag
      always_ff @(posedge sys_clk) begin
        if (!nrst) begin
          flags_q[g] <= 1'b0;
        end else if (eventIn[g]) begin
          flags_q[g] <= 1'b1;
        end else if (readClear) begin
          flags_q[g] <= 1'b0;
        end
      end
    end
  endgenerate

endmodule : phyan_event_flags

/* File: phyan_regs.sv */
/*
  Management register slice of the PHY: partner ability, negotiation expansion,
  local and partner next pages, preamble control, symbol error counter and
  interrupt control/status, with the interrupt output.
  Assumes the management serial engine decodes frames and gives one-cycle read and
  write strobes with a 5-bit register address, and the negotiation engine gives
  one-cycle event pulses and received code words on this clock.

// Behaviour
// - Partner ability bits 8..5 show partner 100/10 full/half ability, reset zero.
// - Partner ability bits 4:0 show partner selector, reset 00001.
// - Expansion bit 4 latches parallel detection fault until read.
// - Expansion bit 1 latches new page received until read.
// - Expansion bit 2 always reads one, local next page able.
// - Expansion bits 3 and 0 show partner next page and negotiation ability.
// - Local next page bit 15 writable more-pages flag, reset zero.
// - Local next page bit 13 writable message page select, reset one.
// - Local next page bit 12 writable will-comply flag, reset zero.
// - Local next page bits 10:0 writable message code, reset one.
// - Local next page bit 11 read-only toggle of previous sent word.
// - Partner next page bits 15, 14, 13 read-only, reset zero.
// - Partner next page bit 12 and bits 10:0 read-only, reset zero.
// - Partner next page bit 11 shows partner toggle, read-only.
// - Preamble bit 7 restores 100 Mbps preamble; strap 100 makes default one.
// - Preamble bit 6 zero strips 10 Mbps preamble to SFD; default zero.
// - Sixteen-bit symbol error frame counter clears when read.
// - Interrupt enables bits 15..9 writable, reset zero.
// - Link-up interrupt enable bit 8 writable, reset zero.
// - Event flags bits 7..0 set on events and clear when read.
*/
`timescale 1ns/1ps
`include "phyan_defs.svh"
module phyan_regs #(
  parameter int ADDR_W = 5,
  parameter int DATA_W = 16
) (
  // Clock and reset.
  input  wire logic              sys_clk,
  input  wire logic              nrst,
  // Management register port.
  input  wire logic [ADDR_W-1:0] regAddr,
  input  wire logic              regWrite,
  input  wire logic              regRead,
  input  wire logic [DATA_W-1:0] regWrData,
  output logic      [DATA_W-1:0] regRdData,
  output logic                   regRdValid,
  // Strap pins, sampled after reset.
  input  wire logic [2:0]        configStrap,
  // Negotiation engine.
  input  wire logic              baseWordValid,
  input  wire logic [DATA_W-1:0] baseWord,
  input  wire logic              nextWordValid,
  input  wire logic [DATA_W-1:0] nextWord,
  input  wire logic              localWordSent,
  input  wire logic              partnerAnAble,
  input  wire logic              pdFault,
  input  wire logic              pageReceived,
  // Receive path.
  input  wire logic              receiveSymbolError,
  // Interrupt events, bit 7 jabber down to bit 0 link up.
  input  wire logic [7:0]        irqEvent,
  // Outputs to the data path and system.
  output logic                   preambleRestore100,
  output logic                   preambleRestore10,
  output logic                   irqOut
);

  // --------------------------------------------------------------------------
  // Access decode.
  // --------------------------------------------------------------------------
  phyan_pkg::phyan_access_type access;
  logic [2:0] strapSync;
  logic       strapTaken_q;

  // A write wins when both strobes arrive together.
  always_comb begin
    access = phyan_pkg::PHYAN_IDLE;
    if (regWrite) begin
      access = phyan_pkg::PHYAN_WRITE;
    end else if (regRead) begin
      access = phyan_pkg::PHYAN_READ;
    end
  end

  logic rdExp;
  logic rdErr;
  logic rdIrq;
  logic wrLocal;
  logic wrPre;
  logic wrIrq;

  assign rdExp   = (access == phyan_pkg::PHYAN_READ) && (regAddr == `PHYAN_OFS_EXPANSION);
  assign rdErr   = (access == phyan_pkg::PHYAN_READ) && (regAddr == `PHYAN_OFS_SYMBOL_ERRORS);
  assign rdIrq   = (access == phyan_pkg::PHYAN_READ) && (regAddr == `PHYAN_OFS_IRQ_CTRL_STATUS);
  assign wrLocal = (access == phyan_pkg::PHYAN_WRITE) && (regAddr == `PHYAN_OFS_LOCAL_NEXT_PAGE);
  assign wrPre   = (access == phyan_pkg::PHYAN_WRITE) && (regAddr == `PHYAN_OFS_PREAMBLE_CTRL);
  assign wrIrq   = (access == phyan_pkg::PHYAN_WRITE) && (regAddr == `PHYAN_OFS_IRQ_CTRL_STATUS);

  // --------------------------------------------------------------------------
  // Strap capture.
  // --------------------------------------------------------------------------
  phyan_sync3 #(
    .WIDTH (3)
  ) uStrapSync (
    .sys_clk (sys_clk),
    .nrst    (nrst),
    .asyncIn (configStrap),
    .syncOut (strapSync)
  );

  // --------------------------------------------------------------------------
  // Partner ability and partner next page.
  // --------------------------------------------------------------------------
  logic [3:0]  partnerSpeed_q;
  logic [4:0]  partnerSel_q;
  logic [15:0] partnerNext_q;
  logic        partnerNpAble_q;
  logic        partnerAnAble_q;

  always_ff @(posedge sys_clk) begin
    if (!nrst) begin
      partnerSpeed_q <= 4'h0;
      partnerSel_q   <= `PHYAN_RST_SELECTOR;
    end else if (baseWordValid) begin
      partnerSpeed_q <= baseWord[8:5];
      partnerSel_q   <= baseWord[4:0];
    end
  end

  // The partner's next page ability is shown in the expansion register only.
  always_ff @(posedge sys_clk) begin
    if (!nrst) begin
      partnerNpAble_q <= 1'b0;
    end else if (baseWordValid) begin
      partnerNpAble_q <= baseWord[`PHYAN_NP_MORE];
    end
  end

  always_ff @(posedge sys_clk) begin
    if (!nrst) begin
      partnerAnAble_q <= 1'b0;
    end else begin
      partnerAnAble_q <= partnerAnAble;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (!nrst) begin
      partnerNext_q <= 16'h0000;
    end else if (nextWordValid) begin
      // Bit 14 is kept as received; it is reserved on the local page only.
      partnerNext_q <= nextWord;
    end
  end

  // --------------------------------------------------------------------------
  // Latch-high expansion flags.
  // --------------------------------------------------------------------------
  logic pdFault_q;
  logic pageRcvd_q;

  always_ff @(posedge sys_clk) begin
    if (!nrst) begin
      pdFault_q  <= 1'b0;
      pageRcvd_q <= 1'b0;
    end else begin
      // A new event in the read cycle wins, so no event is lost.
      pdFault_q  <= pdFault | (pdFault_q & ~rdExp);
      pageRcvd_q <= pageReceived | (pageRcvd_q & ~rdExp);
    end
  end

  // --------------------------------------------------------------------------
  // Local next page.
  // --------------------------------------------------------------------------
  logic        localMore_q;
  logic        localMsg_q;
  logic        localAck2_q;
  logic [10:0] localCode_q;
  logic        localToggle_q;

  // Reset values come from one word, so the fields can never drift apart.
  localparam logic [15:0] LOCAL_RST = `PHYAN_RST_LOCAL_NEXT_PAGE;

  always_ff @(posedge sys_clk) begin
    if (!nrst) begin
      localMore_q <= LOCAL_RST[`PHYAN_NP_MORE];
      localMsg_q  <= LOCAL_RST[`PHYAN_NP_MSG];
      localAck2_q <= LOCAL_RST[`PHYAN_NP_ACK2];
      localCode_q <= LOCAL_RST[10:0];
    end else if (wrLocal) begin
      localMore_q <= regWrData[`PHYAN_NP_MORE];
      localMsg_q  <= regWrData[`PHYAN_NP_MSG];
      localAck2_q <= regWrData[`PHYAN_NP_ACK2];
      localCode_q <= regWrData[10:0];
    end
  end

  // The toggle follows the engine's sends only; writes to bit 11 are dropped.
  always_ff @(posedge sys_clk) begin
    if (!nrst) begin
      localToggle_q <= 1'b0;
    end else if (localWordSent) begin
      localToggle_q <= ~localToggle_q;
    end
  end

  // --------------------------------------------------------------------------
  // Preamble control.
  // --------------------------------------------------------------------------
  logic [2:0] strapWait_q;

  // The synchroniser output is only trusted once the wait count reaches five, five edges after reset.
  always_ff @(posedge sys_clk) begin
    if (!nrst) begin
      strapWait_q <= 3'h0;
    end else if (strapWait_q != `PHYAN_STRAP_SETTLE) begin
      strapWait_q <= strapWait_q + 3'h1;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (!nrst) begin
      strapTaken_q <= 1'b0;
    end else if (wrPre || strapWait_q == `PHYAN_STRAP_SETTLE) begin
      strapTaken_q <= 1'b1;
    end
  end

  // A write made before the strap settles wins, and the strap is then never applied.
  always_ff @(posedge sys_clk) begin
    if (!nrst) begin
      preambleRestore100 <= 1'b0;
      preambleRestore10  <= 1'b0;
    end else if (wrPre) begin
      preambleRestore100 <= regWrData[`PHYAN_PRE_100];
      preambleRestore10  <= regWrData[`PHYAN_PRE_10];
    end else if (!strapTaken_q && strapWait_q == `PHYAN_STRAP_SETTLE) begin
      preambleRestore100 <= (strapSync == `PHYAN_STRAP_PREAMBLE_100);
    end
  end

  // --------------------------------------------------------------------------
  // Symbol error counter.
  // --------------------------------------------------------------------------
  logic [15:0] symErrCount_q;

  always_ff @(posedge sys_clk) begin
    if (!nrst) begin
      symErrCount_q <= 16'h0000;
    end else if (rdErr) begin
      // An error in the read cycle starts the next count rather than vanishing.
      symErrCount_q <= receiveSymbolError ? 16'h0001 : 16'h0000;
    end else if (receiveSymbolError && symErrCount_q != 16'hffff) begin
      // Saturation keeps a long burst from wrapping round to a small count.
      symErrCount_q <= symErrCount_q + 16'h0001;
    end
  end

  // --------------------------------------------------------------------------
  // Interrupt control and status.
  // --------------------------------------------------------------------------
  logic [7:0] irqEnable_q;
  logic [7:0] irqFlags;

  always_ff @(posedge sys_clk) begin
    if (!nrst) begin
      irqEnable_q <= 8'h00;
    end else if (wrIrq) begin
      irqEnable_q <= regWrData[15:8];
    end
  end

  phyan_event_flags #(
    .N (`PHYAN_IRQ_EVENTS)
  ) uIrqFlags (
    .sys_clk   (sys_clk),
    .nrst      (nrst),
    .eventIn   (irqEvent),
    .readClear (rdIrq),
    .flags_q   (irqFlags)
  );

  // Registered, so the pin never glitches while flags and enables change.
  always_ff @(posedge sys_clk) begin
    if (!nrst) begin
      irqOut <= 1'b0;
    end else begin
      irqOut <= |(irqFlags & irqEnable_q);
    end
  end

  // --------------------------------------------------------------------------
  // Read data.
  // --------------------------------------------------------------------------
  logic [15:0] wordExpansion;
  logic [15:0] wordLocal;
  logic [15:0] wordPreamble;
  logic [15:0] rdMux;

  // Reserved bits are tied here, so no write can ever reach them.
  assign wordExpansion = {11'h000, pdFault_q, partnerNpAble_q, 1'b1,
                          pageRcvd_q, partnerAnAble_q};
  assign wordLocal     = {localMore_q, 1'b0, localMsg_q, localAck2_q, localToggle_q, localCode_q};
  assign wordPreamble  = {8'h00, preambleRestore100, preambleRestore10, `PHYAN_RST_PREAMBLE_LOW};

  always_comb begin
    rdMux = 16'h0000;
    unique case (regAddr)
      `PHYAN_OFS_PARTNER_ABILITY: rdMux = {7'h00, partnerSpeed_q, partnerSel_q};
      `PHYAN_OFS_EXPANSION:       rdMux = wordExpansion;
      `PHYAN_OFS_LOCAL_NEXT_PAGE: rdMux = wordLocal;
      `PHYAN_OFS_PARTNER_NEXT:    rdMux = partnerNext_q;
      `PHYAN_OFS_PREAMBLE_CTRL:   rdMux = wordPreamble;
      `PHYAN_OFS_SYMBOL_ERRORS:   rdMux = symErrCount_q;
      `PHYAN_OFS_IRQ_CTRL_STATUS: rdMux = {irqEnable_q, irqFlags};
      default:                    rdMux = 16'h0000;
    endcase
  end

  always_ff @(posedge sys_clk) begin
    if (!nrst) begin
      regRdValid <= 1'b0;
    end else begin
      regRdValid <= (access == phyan_pkg::PHYAN_READ);
    end
  end

  // The last read word stands until the next read, so a slow sampler still sees it.
  always_ff @(posedge sys_clk) begin
    if (!nrst) begin
      regRdData <= 16'h0000;
    end else if (access == phyan_pkg::PHYAN_READ) begin
      regRdData <= rdMux;
    end
  end

endmodule : phyan_regs

/* File: phyan_regs_chk.sv */
/*
  Checker of the negotiation register slice.
  Assumes it is bound to the slice top and sees only its ports.
*/
`timescale 1ns/1ps
module phyan_regs_chk #(
  parameter int ADDR_W = 5,
  parameter int DATA_W = 16
) (
  // Clock and reset.
  input wire logic              sys_clk,
  input wire logic              nrst,
  // Register port.
  input wire logic [ADDR_W-1:0] regAddr,
  input wire logic              regWrite,
  input wire logic              regRead,
  input wire logic [DATA_W-1:0] regWrData,
  input wire logic [DATA_W-1:0] regRdData,
  input wire logic              regRdValid,
  // Events and outputs.
  input wire logic              pdFault,
  input wire logic              pageReceived,
  input wire logic              receiveSymbolError,
  input wire logic [7:0]        irqEvent,
  input wire logic              preambleRestore100,
  input wire logic              preambleRestore10,
  input wire logic              irqOut
);
  default clocking chkClk @(posedge sys_clk); endclocking
  default disable iff (!nrst);
  // ---------------------------------------------------------------
  // Helpers.
  // ---------------------------------------------------------------
  // Shadow latches let a read be held to the exact sticky state.
  logic rd;
  logic pdPend_q;
  logic pgPend_q;
  logic errSeen_q;
  logic anyEvent;
  assign rd = regRead && !regWrite;
  assign anyEvent = |irqEvent;
  always_ff @(posedge sys_clk) begin
    if (!nrst) begin
      pdPend_q  <= 1'b0;
      pgPend_q  <= 1'b0;
      errSeen_q <= 1'b0;
    end else begin
      pdPend_q  <= pdFault || (pdPend_q && !(rd && regAddr == 5'h06));
      pgPend_q  <= pageReceived || (pgPend_q && !(rd && regAddr == 5'h06));
      errSeen_q <= receiveSymbolError || (errSeen_q && !(rd && regAddr == 5'h15));
    end
  end
  a_read_answered: assert property (rd |=> regRdValid)
    else $error("read not answered");
  a_exp_fixed: assert property (rd && regAddr == 5'h06 |=> regRdData[2] && regRdData[15:5] == 11'h000)
    else $error("expansion fixed bits wrong");
  a_exp_latched: assert property (rd && regAddr == 5'h06 |=>
    regRdData[4] == $past(pdPend_q) && regRdData[1] == $past(pgPend_q))
    else $error("expansion latched bits wrong");
  a_ability_upper: assert property (rd && regAddr == 5'h05 |=> regRdData[15:9] == 7'h00)
    else $error("ability upper bits not zero");
  a_np_reserved: assert property (rd && regAddr == 5'h07 |=> !regRdData[14])
    else $error("next page reserved bit set");
  a_pre_fixed: assert property (rd && regAddr == 5'h14 |=>
    regRdData[15:8] == 8'h00 && regRdData[5:0] == 6'h01)
    else $error("preamble reserved bits wrong");
  a_pre_out100: assert property (regWrite && regAddr == 5'h14 |=> preambleRestore100 == $past(regWrData[7]))
    else $error("fast preamble output wrong");
  a_pre_out10: assert property (regWrite && regAddr == 5'h14 |=> preambleRestore10 == $past(regWrData[6]))
    else $error("slow preamble output wrong");
  a_cnt_cleared: assert property (rd && regAddr == 5'h15 && !errSeen_q && !receiveSymbolError |=>
    regRdData == 16'h0000)
    else $error("error counter not cleared");
  a_irq_cause: assert property ($rose(irqOut) |-> $past(anyEvent, 2) || $past(regWrite, 2))
    else $error("interrupt rose without cause");
  a_irq_clear: assert property (rd && regAddr == 5'h1b && irqEvent == 8'h00 |-> ##2 !irqOut)
    else $error("interrupt stayed after flag read");
endmodule : phyan_regs_chk

/* File: phyan_mgmt_model.sv */
/*
  Management controller model driving the slice's strobe port.
  Assumes callers enter each task just after a rising clock edge.
*/
`timescale 1ns/1ps
module phyan_mgmt_model (
  // Clock.
  input  wire logic        sys_clk,
  // Register port.
  output logic      [4:0]  regAddr,
  output logic             regWrite,
  output logic             regRead,
  output logic      [15:0] regWrData,
  input  wire logic [15:0] regRdData,
  input  wire logic        regRdValid
);
  initial begin
    regAddr   = 5'h00;
    regWrite  = 1'b0;
    regRead   = 1'b0;
    regWrData = 16'h0000;
  end
  // Released lines show the inverse, so a stale value never looks valid.
  task automatic reg_write(input logic [4:0] a, input logic [15:0] d);
    regAddr   = a;
    regWrData = d;
    regWrite  = 1'b1;
    @(posedge sys_clk) #1;
    regWrite  = 1'b0;
    regAddr   = ~a;
    regWrData = ~d;
    @(posedge sys_clk) #1;
  endtask : reg_write
  task automatic reg_read(input logic [4:0] a, output logic [15:0] d, output logic ok);
    int i;
    regAddr = a;
    regRead = 1'b1;
    @(posedge sys_clk) #1;
    regRead = 1'b0;
    regAddr = ~a;
    ok      = 1'b0;
    for (i = 0; i < 4 && !ok; i++) begin
      if (regRdValid === 1'b1) begin
        ok = 1'b1;
        d  = regRdData;
      end else begin
        @(posedge sys_clk) #1;
      end
    end
    @(posedge sys_clk) #1;
  endtask : reg_read
endmodule : phyan_mgmt_model

/* File: testbench.sv */
/*
  Self-checking bench of the negotiation register slice.
  Assumes the controller model and the checker are compiled first.
*/
`timescale 1ns/1ps
`define PHYAN_CHK(g, e) \
  begin \
    n_compared++; \
    if ((g) !== (e)) begin \
      failures++; \
      $display("BAD t=%0t got=%h exp=%h", $time, (g), (e)); \
    end \
  end
module testbench;
  logic        sys_clk;
  logic        nrst;
  logic [4:0]  regAddr;
  logic        regWrite;
  logic        regRead;
  logic [15:0] regWrData;
  logic [15:0] regRdData;
  logic        regRdValid;
  logic [2:0]  configStrap;
  logic        baseWordValid;
  logic [15:0] baseWord;
  logic        nextWordValid;
  logic [15:0] nextWord;
  logic        localWordSent;
  logic        partnerAnAble;
  logic        pdFault;
  logic        pageReceived;
  logic        receiveSymbolError;
  logic [7:0]  irqEvent;
  logic        preambleRestore100;
  logic        preambleRestore10;
  logic        irqOut;
  int          failures;
  int          n_compared;
  int          i;
  localparam logic [4:0]  ADDRS [8] = '{5'h05, 5'h06, 5'h07, 5'h08, 5'h14, 5'h15, 5'h1b, 5'h00};
  localparam logic [15:0] RSTV  [8] = '{16'h0001, 16'h0004, 16'h2001, 16'h0000,
                                        16'h0001, 16'h0000, 16'h0000, 16'h0000};
  localparam logic [15:0] FULLV [8] = '{16'h0001, 16'h0004, 16'hb7ff, 16'h0000,
                                        16'h00c1, 16'h0000, 16'hff00, 16'h0000};
  phyan_regs u_phyan_regs (.sys_clk, .nrst, .regAddr, .regWrite, .regRead, .regWrData, .regRdData, .regRdValid,
    .configStrap, .baseWordValid, .baseWord, .nextWordValid, .nextWord, .localWordSent, .partnerAnAble, .pdFault,
    .pageReceived, .receiveSymbolError, .irqEvent, .preambleRestore100, .preambleRestore10, .irqOut);
  phyan_mgmt_model u_phyan_mgmt_model (.sys_clk, .regAddr, .regWrite, .regRead, .regWrData, .regRdData,
    .regRdValid);
  always #12.5 sys_clk = ~sys_clk;
  task automatic tick();
    @(posedge sys_clk) #1;
  endtask : tick
  task automatic report_and_stop();
    $display("compared %0d mismatched %0d", n_compared, failures);
    if (failures == 0 && n_compared > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask : report_and_stop
  task automatic rd_chk(input logic [4:0] a, input logic [15:0] e);
    logic [15:0] d;
    logic        ok;
    u_phyan_mgmt_model.reg_read(a, d, ok);
    if (ok !== 1'b1) begin
      failures++;
      report_and_stop();
    end
    `PHYAN_CHK(d, e)
  endtask : rd_chk
  initial begin
    sys_clk = 1'b0;
    nrst = 1'b0;
    failures = 0;
    n_compared = 0;
    configStrap = 3'h0;
    {baseWordValid, nextWordValid, localWordSent, partnerAnAble, pdFault, pageReceived, receiveSymbolError} = 7'h00;
    {baseWord, nextWord} = 32'h0;
    irqEvent = 8'h00;
    repeat (3) @(posedge sys_clk);
    #1 nrst = 1'b1;
    for (i = 0; i < 8; i++) rd_chk(ADDRS[i], RSTV[i]);
    $display("reset values done");
    for (i = 0; i < 8; i++) begin
      u_phyan_mgmt_model.reg_write(ADDRS[i], 16'hffff);
      rd_chk(ADDRS[i], FULLV[i]);
    end
    `PHYAN_CHK({preambleRestore100, preambleRestore10}, 2'h3)
    u_phyan_mgmt_model.reg_write(5'h14, 16'h0080);
    `PHYAN_CHK({preambleRestore100, preambleRestore10}, 2'h2)
    rd_chk(5'h14, 16'h0081);
    $display("write access done");
    localWordSent = 1'b1;
    tick();
    localWordSent = 1'b0;
    rd_chk(5'h07, 16'hbfff);
    u_phyan_mgmt_model.reg_write(5'h07, 16'h0000);
    rd_chk(5'h07, 16'h0800);
    $display("local page done");
    {pdFault, pageReceived} = 2'h3;
    tick();
    {pdFault, pageReceived} = 2'h0;
    rd_chk(5'h06, 16'h0016);
    rd_chk(5'h06, 16'h0004);
    partnerAnAble = 1'b1;
    baseWord = 16'h81e2;
    baseWordValid = 1'b1;
    nextWord = 16'hd9a5;
    nextWordValid = 1'b1;
    tick();
    {baseWordValid, nextWordValid} = 2'h0;
    rd_chk(5'h05, 16'h01e2);
    rd_chk(5'h06, 16'h000d);
    rd_chk(5'h08, 16'hd9a5);
    $display("partner words done");
    repeat (3) begin
      receiveSymbolError = 1'b1;
      tick();
      receiveSymbolError = 1'b0;
      tick();
    end
    rd_chk(5'h15, 16'h0003);
    rd_chk(5'h15, 16'h0000);
    $display("error counter done");
    for (i = 0; i < 8; i++) begin
      u_phyan_mgmt_model.reg_write(5'h1b, 16'h0100 << i);
      irqEvent = 8'h01 << i;
      tick();
      irqEvent = 8'h00;
      tick();
      tick();
      `PHYAN_CHK(irqOut, 1'b1)
      rd_chk(5'h1b, 16'h0101 << i);
      tick();
      `PHYAN_CHK(irqOut, 1'b0)
    end
    u_phyan_mgmt_model.reg_write(5'h1b, 16'h0000);
    irqEvent = 8'hff;
    tick();
    irqEvent = 8'h00;
    tick();
    tick();
    `PHYAN_CHK(irqOut, 1'b0)
    rd_chk(5'h1b, 16'h00ff);
    $display("interrupts done");
    configStrap = 3'h4;
    nrst = 1'b0;
    repeat (3) tick();
    nrst = 1'b1;
    repeat (8) tick();
    `PHYAN_CHK({preambleRestore100, preambleRestore10, irqOut}, 3'h4)
    rd_chk(5'h14, 16'h0081);
    rd_chk(5'h05, 16'h0001);
    rd_chk(5'h08, 16'h0000);
    $display("strap reset done");
    report_and_stop();
  end
endmodule : testbench
bind phyan_regs phyan_regs_chk #(.ADDR_W(ADDR_W), .DATA_W(DATA_W)) u_phyan_regs_chk (.sys_clk, .nrst, .regAddr,
  .regWrite, .regRead, .regWrData, .regRdData, .regRdValid, .pdFault, .pageReceived, .receiveSymbolError,
  .irqEvent, .preambleRestore100, .preambleRestore10, .irqOut);
